// [core/bcal_core.sv]
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module bcal_core (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic rtc_tick_i,
  input wire logic [bcal_pkg::ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic second_pulse_o
);
  import bcal_pkg::*;

  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [15:0] rd_val;
  logic [15:0] wkhr_reg;
  logic [15:0] mmss_reg;
  logic [15:0] amd_reg;
  logic [15:0] awkhr_reg;
  logic [15:0] aminsec_reg;
  logic [CAL_W-1:0] cal_reg;
  logic [1:0] ptr_reg;
  logic wren_reg;
  logic en_reg;
  logic signed [PRESC_W-1:0] presc_reg;
  logic sec_pulse_reg;
  logic req;
  logic rd_go;
  logic wr_go;
  logic win_acc;
  logic we_wkhr;
  logic we_mmss;
  logic mmss_lo_wr;
  logic sec_tick;
  logic minute_end;
  logic half_flag;
  logic [PRESC_W-1:0] cal_adj;
  logic [7:0] pair_in [NPAIR];
  logic [7:0] pair_out [NPAIR];
  logic [NPAIR:0] carry;
  logic [2:0] wkday_next;
  logic [15:0] mmss_cnt;
  logic [15:0] wkhr_cnt;

  // merge byte lanes into a 16-bit register, unimplemented bits forced low
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v, input logic [31:0] wd,
                                             input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old_v;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    return v & mask;
  endfunction : lane_merge

  // true when a taken access hits the given byte address
  function automatic logic hit(input logic go, input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return go && (a == off);
  endfunction : hit

  // bus handshake: one wait cycle, then the access is taken
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign rd_go = ce_i & avs_read_i & ack_reg;
  assign wr_go = ce_i & avs_write_i & ack_reg;
  assign avs_readdata_o = rdata_reg;
  assign second_pulse_o = sec_pulse_reg;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // write strobes; window follows the pointer, protected registers need enable
  assign win_acc = hit(rd_go | wr_go, avs_address_i, OFF_WIN);
  assign we_wkhr = wren_reg & (hit(wr_go, avs_address_i, OFF_WKHR) ||
                   (hit(wr_go, avs_address_i, OFF_WIN) && ptr_reg == PTR_WKHR));
  assign we_mmss = wren_reg & (hit(wr_go, avs_address_i, OFF_MMSS) ||
                   (hit(wr_go, avs_address_i, OFF_WIN) && ptr_reg == PTR_MMSS));
  // any minutes/seconds low-half write, direct or through the window, restarts the second, locked or not
  assign mmss_lo_wr = avs_byteenable_i[0] & (hit(wr_go, avs_address_i, OFF_MMSS) ||
                      (hit(wr_go, avs_address_i, OFF_WIN) && ptr_reg == PTR_MMSS));

  // prescaler: second ends at the last count, minute end loads calibration
  assign sec_tick = ce_i & en_reg & rtc_tick_i & (presc_reg == PRESC_LAST);
  assign minute_end = carry[1];
  assign cal_adj = {{(PRESC_W-CAL_W-CAL_SHIFT){cal_reg[CAL_W-1]}}, cal_reg, {CAL_SHIFT{1'b0}}};
  assign half_flag = ~presc_reg[PRESC_W-1] & (presc_reg >= PRESC_HALF);

  // a negative start stretches the next second, a positive one shortens it
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      presc_reg <= '0;
    end else if (ce_i) begin
      if (mmss_lo_wr) begin
        presc_reg <= '0;
      end else if (sec_tick) begin
        presc_reg <= minute_end ? cal_adj : '0;
      end else if (en_reg && rtc_tick_i) begin
        presc_reg <= presc_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sec_pulse_reg <= 1'b0;
    end else if (ce_i) begin
      sec_pulse_reg <= sec_tick;
    end
  end

  // bcd counting chain seconds -> minutes -> hours -> weekday
  assign pair_in[0] = {1'b0, mmss_reg[SEC_MSB:PAIR_LSB]};
  assign pair_in[1] = {1'b0, mmss_reg[MIN_MSB:MIN_LSB]};
  assign pair_in[2] = {2'b00, wkhr_reg[HR_MSB:PAIR_LSB]};
  assign carry[0] = sec_tick;

  generate
    for (genvar i = 0; i < NPAIR; i++) begin : g_pair
      bcal_bcd_step u_step (
        .pair_i(pair_in[i]),
        .carry_i(carry[i]),
        .last_i(PAIR_LAST[i*8 +: 8]),
        .pair_o(pair_out[i]),
        .carry_o(carry[i+1])
      );
    end
  endgenerate

  // weekday wraps after six
  assign wkday_next = !carry[NPAIR] ? wkhr_reg[WKDAY_MSB:WKDAY_LSB] :
                      (wkhr_reg[WKDAY_MSB:WKDAY_LSB] >= WKDAY_LAST) ? 3'h0 :
                      wkhr_reg[WKDAY_MSB:WKDAY_LSB] + 3'h1;
  assign mmss_cnt = {1'b0, pair_out[1][6:0], 1'b0, pair_out[0][6:0]} & MMSS_MASK;
  assign wkhr_cnt = {5'h00, wkday_next, 2'b00, pair_out[2][5:0]} & WKHR_MASK;

  // software write beats the counting update in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mmss_reg <= RESET_VAL;
    end else if (ce_i) begin
      if (we_mmss) begin
        mmss_reg <= lane_merge(mmss_reg, avs_writedata_i, avs_byteenable_i, MMSS_MASK);
      end else if (sec_tick) begin
        mmss_reg <= mmss_cnt;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wkhr_reg <= RESET_VAL;
    end else if (ce_i) begin
      if (we_wkhr) begin
        wkhr_reg <= lane_merge(wkhr_reg, avs_writedata_i, avs_byteenable_i, WKHR_MASK);
      end else if (sec_tick) begin
        wkhr_reg <= wkhr_cnt;
      end
    end
  end

  // alarm values; month/day and weekday/hours share the time lock
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      amd_reg <= RESET_VAL;
      awkhr_reg <= RESET_VAL;
      aminsec_reg <= RESET_VAL;
    end else if (ce_i) begin
      if (wren_reg && hit(wr_go, avs_address_i, OFF_AMD)) begin
        amd_reg <= lane_merge(amd_reg, avs_writedata_i, avs_byteenable_i, AMD_MASK);
      end
      if (wren_reg && hit(wr_go, avs_address_i, OFF_AWKHR)) begin
        awkhr_reg <= lane_merge(awkhr_reg, avs_writedata_i, avs_byteenable_i, WKHR_MASK);
      end
      if (hit(wr_go, avs_address_i, OFF_AMINSEC)) begin
        aminsec_reg <= lane_merge(aminsec_reg, avs_writedata_i, avs_byteenable_i, MMSS_MASK);
      end
    end
  end

  // config: calibration any time, run bit only while unlocked
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cal_reg <= '0;
      wren_reg <= 1'b0;
      en_reg <= 1'b0;
    end else if (ce_i && hit(wr_go, avs_address_i, OFF_CFG)) begin
      if (avs_byteenable_i[0]) cal_reg <= avs_writedata_i[CAL_W-1:0];
      if (avs_byteenable_i[1]) begin
        wren_reg <= avs_writedata_i[CFG_WREN_BIT];
        if (wren_reg) en_reg <= avs_writedata_i[CFG_EN_BIT];
      end
    end
  end

  // window pointer walks down per window access and sticks at zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ptr_reg <= 2'h0;
    end else if (ce_i) begin
      if (hit(wr_go, avs_address_i, OFF_CFG) && avs_byteenable_i[1]) begin
        ptr_reg <= avs_writedata_i[CFG_PTR_MSB:CFG_PTR_LSB];
      end else if (win_acc && ptr_reg != 2'h0) begin
        ptr_reg <= ptr_reg - 2'h1;
      end
    end
  end

  // read mux; unmapped addresses and window slots out of range read zero
  always_comb begin
    rd_val = 16'h0000;
    case (avs_address_i)
      OFF_CFG: begin
        rd_val[CAL_W-1:0] = cal_reg;
        rd_val[CFG_PTR_MSB:CFG_PTR_LSB] = ptr_reg;
        rd_val[CFG_HALF_BIT] = half_flag;
        rd_val[CFG_WREN_BIT] = wren_reg;
        rd_val[CFG_EN_BIT] = en_reg;
      end
      OFF_WIN: begin
        if (ptr_reg == PTR_MMSS) rd_val = mmss_reg;
        else if (ptr_reg == PTR_WKHR) rd_val = wkhr_reg;
        else rd_val = 16'h0000;
      end
      OFF_WKHR: rd_val = wkhr_reg;
      OFF_MMSS: rd_val = mmss_reg;
      OFF_AMD: rd_val = amd_reg;
      OFF_AWKHR: rd_val = awkhr_reg;
      OFF_AMINSEC: rd_val = aminsec_reg;
      default: rd_val = 16'h0000;
    endcase
  end

  // capture in the wait cycle so data stands at the accepting edge
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 32'h00000000;
    end else if (ce_i && avs_read_i && !ack_reg) begin
      rdata_reg <= {16'h0000, rd_val};
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_wait_one;
    (ce_i && req && !ack_reg) |=> (ack_reg && !avs_waitrequest_o);
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not released after one cycle");

  property p_unimpl_zero;
    ((wkhr_reg & ~WKHR_MASK) == 16'h0000) && ((mmss_reg & ~MMSS_MASK) == 16'h0000) &&
    ((amd_reg & ~AMD_MASK) == 16'h0000) && (avs_readdata_o[31:16] == 16'h0000);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit set");

  property p_wkhr_lock;
    (wr_go && avs_address_i == OFF_WKHR && !wren_reg && !sec_tick) |=> $stable(wkhr_reg);
  endproperty
  a_wkhr_lock: assert property (p_wkhr_lock) else $error("locked weekday/hours changed");

  property p_mmss_lock;
    (wr_go && avs_address_i == OFF_MMSS && !wren_reg && !sec_tick) |=> $stable(mmss_reg);
  endproperty
  a_mmss_lock: assert property (p_mmss_lock) else $error("locked minutes/seconds changed");

  property p_half_clear;
    (mmss_lo_wr) |=> (!half_flag && presc_reg == '0);
  endproperty
  a_half_clear: assert property (p_half_clear) else $error("half flag not cleared by low write");

  property p_ptr_dec;
    (win_acc && ptr_reg != 2'h0 && !hit(wr_go, avs_address_i, OFF_CFG)) |=> (ptr_reg == $past(ptr_reg) - 2'h1);
  endproperty
  a_ptr_dec: assert property (p_ptr_dec) else $error("window pointer did not step down");

  property p_cal_load;
    (sec_tick && minute_end && !mmss_lo_wr) |=> (presc_reg == $signed($past(cal_adj)));
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibration not applied at minute end");

  property p_sec_wrap;
    (sec_tick && !we_mmss && mmss_reg[SEC_MSB:PAIR_LSB] == 7'h59) |=>
      (mmss_reg[SEC_MSB:PAIR_LSB] == 7'h00 && second_pulse_o);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap) else $error("seconds did not wrap to zero");

  property p_cal_scale;
    // arithmetic product, so a slip in the lane concatenation shows up
    $signed(cal_adj) == $signed(cal_reg) * (17'sh00001 <<< CAL_SHIFT);
  endproperty
  a_cal_scale: assert property (p_cal_scale) else $error("calibration step not four counts");

  c_minute_cal: cover property (sec_tick && minute_end && cal_reg != '0);
  c_ptr_walk: cover property (win_acc && ptr_reg == PTR_WKHR ##[1:20] win_acc && ptr_reg == PTR_MMSS);
  c_locked_write: cover property (wr_go && !wren_reg && avs_address_i == OFF_WKHR);
  c_hour_carry: cover property (carry[NPAIR]);
endmodule : bcal_core
`default_nettype wire

// [core/bcal_pkg.sv]
// Function
// - weekday field bits 10-8, values 0-6
// - hours tens field bits 5-4, 0-2
// - hours ones field bits 3-0, 0-9
// - minutes tens field bits 14-12, 0-5
// - minutes ones field bits 11-8, 0-9
// - seconds tens field bits 6-4, 0-5
// - seconds ones field bits 3-0, 0-9
// - alarm month tens single bit 12
// - alarm month ones bits 11-8
// - alarm day tens bits 5-4, 0-3
// - alarm day ones bits 3-0
// - unimplemented bits read zero, ignore writes
// - protected value registers writable only when enabled
// - once a minute apply four times calibration
// - positive adds counts, negative subtracts counts
// - time values locked while write enable clear
// - minutes/seconds low write clears half flag
// - window pointer decrements per access, stops 00
package bcal_pkg;
  // register map, byte addresses on the avalon slave
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_CFG = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_WIN = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_WKHR = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_MMSS = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_AMD = 5'h10;
  localparam logic [ADDR_W-1:0] OFF_AWKHR = 5'h14;
  localparam logic [ADDR_W-1:0] OFF_AMINSEC = 5'h18;
  // implemented bits of each value register
  localparam logic [15:0] WKHR_MASK = 16'h073F;
  localparam logic [15:0] MMSS_MASK = 16'h7F7F;
  localparam logic [15:0] AMD_MASK = 16'h1F3F;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // field positions
  localparam int WKDAY_MSB = 10;
  localparam int WKDAY_LSB = 8;
  localparam int HR_MSB = 5;
  localparam int MIN_MSB = 14;
  localparam int MIN_LSB = 8;
  localparam int SEC_MSB = 6;
  localparam int PAIR_LSB = 0;
  localparam logic [2:0] WKDAY_LAST = 3'h6;
  // config register layout
  localparam int CAL_W = 8;
  localparam int CAL_SHIFT = 2;
  localparam int CFG_PTR_LSB = 8;
  localparam int CFG_PTR_MSB = 9;
  localparam int CFG_HALF_BIT = 11;
  localparam int CFG_WREN_BIT = 13;
  localparam int CFG_EN_BIT = 15;
  localparam logic [1:0] PTR_MMSS = 2'h0;
  localparam logic [1:0] PTR_WKHR = 2'h1;
  // timekeeping prescaler, one second of 32768 counts
  localparam int PRESC_W = 17;
  localparam logic [PRESC_W-1:0] PRESC_LAST = 17'h07FFF;
  localparam logic [PRESC_W-1:0] PRESC_HALF = 17'h04000;
  // last value of seconds, minutes, hours pairs
  localparam int NPAIR = 3;
  localparam logic [NPAIR*8-1:0] PAIR_LAST = 24'h235959;
endpackage : bcal_pkg

// [core/bcal_bcd_step.sv]
`timescale 1ns/1ps
`default_nettype none
module bcal_bcd_step (
  input wire logic [7:0] pair_i,
  input wire logic carry_i,
  input wire logic [7:0] last_i,
  output logic [7:0] pair_o,
  output logic carry_o
);
  // two-digit bcd increment with wrap to 00
  always_comb begin
    pair_o = pair_i;
    carry_o = 1'b0;
    if (carry_i) begin
      if (pair_i == last_i) begin
        pair_o = 8'h00;
        carry_o = 1'b1;
      end else if (pair_i[3:0] >= 4'h9) begin
        pair_o = {pair_i[7:4] + 4'h1, 4'h0};
      end else begin
        pair_o = {pair_i[7:4], pair_i[3:0] + 4'h1};
      end
    end
  end
endmodule : bcal_bcd_step
`default_nettype wire

// [tb/bcal_core_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module bcal_core_bench;
  import bcal_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic rtc_tick_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = 5'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic second_pulse_o;
  logic [31:0] rdata;
  int miscompares = 0;
  int checks = 0;
  localparam logic [ADDR_W-1:0] OFFS [7] = '{OFF_CFG, OFF_WIN, OFF_WKHR, OFF_MMSS, OFF_AMD, OFF_AWKHR, OFF_AMINSEC};
  localparam logic [15:0] MASKS [7] = '{16'h0000, 16'h0000, WKHR_MASK, MMSS_MASK, AMD_MASK, WKHR_MASK, MMSS_MASK};
  // one hertz of oscillator error either way, turned into counts per minute
  localparam int IDEAL_HZ = 32768;
  localparam int SEC_TICKS = IDEAL_HZ;
  localparam int HALF_TICKS = IDEAL_HZ / 2;
  localparam int ERR_FAST = (IDEAL_HZ - (IDEAL_HZ + 1)) * 60;
  localparam int ERR_SLOW = (IDEAL_HZ - (IDEAL_HZ - 1)) * 60;
  localparam logic [7:0] CAL_FAST = 8'(ERR_FAST / 4);
  localparam logic [7:0] CAL_SLOW = 8'(ERR_SLOW / 4);
  int pulses = 0;

  // free running 250 MHz core clock
  always #2 core_clk_i = ~core_clk_i;

  // second pulses counted, checked against the seconds that ended
  always @(posedge core_clk_i) begin
    if (second_pulse_o === 1'b1) pulses++;
  end

  bcal_core dut (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .rtc_tick_i(rtc_tick_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .second_pulse_o(second_pulse_o)
  );

  // verdict, reached from the main sequence or the watchdog
  task automatic summarize();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  // one avalon transfer; waitrequest and readdata taken at the rising edge, request held until then
  task automatic bus(input logic wr_en, input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= {16'h0000, d};
    avs_byteenable_i <= be;
    avs_write_i <= wr_en;
    avs_read_i <= ~wr_en;
    @(posedge core_clk_i);
    while (avs_waitrequest_o !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk_i);
    end
    if (n >= 20) cmp(32'h00000001, 32'h00000000);
    rdata = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // idle cycle so release and the next request never land in one step
    @(posedge core_clk_i);
  endtask : bus

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [3:0] be = 4'h3);
    bus(1'b1, a, d, be);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    bus(1'b0, a, 16'h0000, 4'h3);
    cmp(rdata, {16'h0000, exp});
  endtask : rd

  // back-to-back timekeeping counts, one per core cycle
  task automatic ticks(input int n);
    rtc_tick_i <= 1'b1;
    repeat (n) @(posedge core_clk_i);
    rtc_tick_i <= 1'b0;
  endtask : ticks

  // tick counts dominate: about 98.5k cycles expected for the whole run
  initial begin
    repeat (99000) @(posedge core_clk_i);
    miscompares++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge core_clk_i);
    for (int i = 0; i < 7; i++) begin
      rd(OFFS[i], RESET_VAL);
    end
    $display("test reset values done");

    // protected registers refuse writes while write enable is clear
    for (int i = 2; i < 6; i++) begin
      wr(OFFS[i], 16'hFFFF);
      rd(OFFS[i], 16'h0000);
    end
    wr(OFF_CFG, 16'h8000);
    rd(OFF_CFG, 16'h0000);
    wr(OFF_AMINSEC, 16'hFFFF, 4'h1);
    rd(OFF_AMINSEC, 16'h007F);
    wr(5'h1C, 16'hFFFF);
    rd(5'h1C, 16'h0000);
    $display("test write lock done");

    // all ones written, only implemented field bits come back
    wr(OFF_CFG, 16'h2000);
    rd(OFF_CFG, 16'h2000);
    for (int i = 2; i < 7; i++) begin
      wr(OFFS[i], 16'hFFFF);
      rd(OFFS[i], MASKS[i]);
    end
    $display("test field masks done");

    // window pointer steps down per access and parks at zero
    wr(OFF_WKHR, 16'h0512);
    wr(OFF_MMSS, 16'h3407);
    wr(OFF_CFG, 16'h2100);
    rd(OFF_WIN, 16'h0512);
    rd(OFF_CFG, 16'h2000);
    rd(OFF_WIN, 16'h3407);
    rd(OFF_CFG, 16'h2000);
    wr(OFF_WIN, 16'h1234);
    rd(OFF_MMSS, 16'h1234);
    wr(OFF_CFG, 16'h2200);
    rd(OFF_WIN, 16'h0000);
    rd(OFF_CFG, 16'h2100);
    $display("test window done");

    // full carry chain; fast-oscillator calibration written while the timer is off
    wr(OFF_WKHR, 16'h0623);
    wr(OFF_MMSS, 16'h5959);
    wr(OFF_CFG, {8'hA0, CAL_FAST});
    ticks(SEC_TICKS);
    rd(OFF_WKHR, 16'h0000);
    rd(OFF_MMSS, 16'h0000);
    // negative start after the minute: half mark comes late by four counts a step
    ticks(HALF_TICKS - ERR_FAST - 1);
    rd(OFF_CFG, {8'hA0, CAL_FAST});
    ticks(1);
    rd(OFF_CFG, {8'hA8, CAL_FAST});
    $display("test negative calibration done");

    // slow oscillator: timer stopped while the calibration byte changes
    wr(OFF_CFG, 16'h2000, 4'h2);
    wr(OFF_CFG, {8'h20, CAL_SLOW}, 4'h1);
    wr(OFF_MMSS, 16'h0059);
    wr(OFF_CFG, 16'hA000, 4'h2);
    ticks(SEC_TICKS);
    rd(OFF_MMSS, 16'h0100);
    // clock enable low must hold the prescaler through these counts
    ce_i <= 1'b0;
    ticks(8);
    ce_i <= 1'b1;
    rd(OFF_CFG, {8'hA0, CAL_SLOW});
    ticks(HALF_TICKS - ERR_SLOW - 1);
    rd(OFF_CFG, {8'hA0, CAL_SLOW});
    ticks(1);
    rd(OFF_CFG, {8'hA8, CAL_SLOW});
    wr(OFF_MMSS, 16'h0030, 4'h1);
    rd(OFF_CFG, {8'hA0, CAL_SLOW});
    rd(OFF_MMSS, 16'h0130);
    cmp(pulses, 32'h00000002);
    $display("test positive calibration done");
    summarize();
  end
endmodule : bcal_core_bench
`default_nettype wire
